// ### hw/sof_formatter.sv
// Serial output formatter: latency pipeline, word crossing and DDR lane serialiser
`timescale 1ns/1ns
// Contract
// - Sample delay 11 cycles, 8 when low-latency
// - 12-bit format drops two sample LSBs
// - 16-bit format appends two zero LSBs
// - Bit clock is 6/7/8 times frame clock rate
// - Frame clock launched like the data lane
// - Frame clock high half, low half
module sof_formatter
  import sof_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic link_clk_i,
  input wire logic [13:0] sample_i,
  input wire logic spi_sen_n_i,
  input wire logic spi_sclk_i,
  input wire logic spi_sdata_i,
  output logic sdout_o,
  output logic sdout_oe_o,
  output logic serial_data_o,
  output logic serial_bit_clock_o,
  output logic word_frame_clock_o
);
  logic [15:0] ctrl_reg;
  logic [15:0] latency_control_reg;
  logic [15:0] output_rate_select_reg;
  logic [15:0] lsb_trim_select_reg;
  logic [15:0] rd_data;
  logic [7:0] rd_addr;
  logic wr_strobe;
  logic [7:0] wr_addr;
  logic [15:0] wr_data;
  logic [13:0] pipe_reg [0:SOF_LAT_DEFAULT-1];
  logic [13:0] delayed_sample;
  logic [13:0] xfer_data_reg;
  logic xfer_flag_reg;
  logic [1:0] ack_sync_reg;
  logic [1:0] link_rst_reg;
  logic link_rst;
  logic [1:0] flag_sync_reg;
  logic flag_seen_reg;
  logic [13:0] word_hold_reg;
  logic [5:0] fmt_sync_reg;
  sof_fmt_t fmt_act_reg;
  sof_fmt_t fmt_next;
  logic [4:0] bit_cnt_reg;
  logic [4:0] bit_cnt_next;
  logic [4:0] word_bits;
  logic [15:0] shift_reg;

  function automatic logic [4:0] sof_word_bits(input sof_fmt_t fmt);
    case (fmt)
      SOF_FMT_12: sof_word_bits = SOF_BITS_12;
      SOF_FMT_16: sof_word_bits = SOF_BITS_16;
      default: sof_word_bits = SOF_BITS_14;
    endcase
  endfunction

  function automatic logic [15:0] sof_format_word(input sof_fmt_t fmt, input logic [13:0] s);
    case (fmt)
      SOF_FMT_12: sof_format_word = {s[13:2], 4'h0};
      SOF_FMT_16: sof_format_word = {s, 2'b00};
      default: sof_format_word = {s, 2'b00};
    endcase
  endfunction

  sof_spi_port u_spi (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .spi_sen_n_i(spi_sen_n_i),
    .spi_sclk_i(spi_sclk_i),
    .spi_sdata_i(spi_sdata_i),
    .readout_en_i(ctrl_reg[SOF_READOUT_BIT]),
    .rd_data_i(rd_data),
    .rd_addr_o(rd_addr),
    .wr_strobe_o(wr_strobe),
    .wr_addr_o(wr_addr),
    .wr_data_o(wr_data),
    .sdout_o(sdout_o),
    .sdout_oe_o(sdout_oe_o)
  );

  always_comb
  begin
    case (rd_addr)
      SOF_ADDR_CTRL: rd_data = ctrl_reg;
      SOF_ADDR_LATENCY: rd_data = latency_control_reg;
      SOF_ADDR_RATE: rd_data = output_rate_select_reg;
      SOF_ADDR_TRIM: rd_data = lsb_trim_select_reg;
      default: rd_data = 16'h0000;
    endcase
  end

  // Soft reset clears all fields and drops itself; in readout mode only the
  // control register accepts writes so the readout bit can be turned off
  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      ctrl_reg <= SOF_REG_RESET;
      latency_control_reg <= SOF_REG_RESET;
      output_rate_select_reg <= SOF_REG_RESET;
      lsb_trim_select_reg <= SOF_REG_RESET;
    end
    else if (wr_strobe)
    begin
      if (wr_addr == SOF_ADDR_CTRL && wr_data[SOF_SOFT_RESET_BIT])
      begin
        ctrl_reg <= SOF_REG_RESET;
        latency_control_reg <= SOF_REG_RESET;
        output_rate_select_reg <= SOF_REG_RESET;
        lsb_trim_select_reg <= SOF_REG_RESET;
      end
      else if (wr_addr == SOF_ADDR_CTRL)
        ctrl_reg <= {14'h0000, wr_data[SOF_READOUT_BIT], 1'b0};
      else if (!ctrl_reg[SOF_READOUT_BIT])
      begin
        if (wr_addr == SOF_ADDR_LATENCY)
          latency_control_reg <= wr_data;
        if (wr_addr == SOF_ADDR_RATE)
          output_rate_select_reg <= wr_data;
        if (wr_addr == SOF_ADDR_TRIM)
          lsb_trim_select_reg <= {13'h0000, wr_data[SOF_TRIM_MSB:0]};
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      for (int i = 0; i < SOF_LAT_DEFAULT; i++)
        pipe_reg[i] <= 14'h0000;
    end
    else
    begin
      pipe_reg[0] <= sample_i;
      for (int i = 1; i < SOF_LAT_DEFAULT; i++)
        pipe_reg[i] <= pipe_reg[i-1];
    end
  end

  assign delayed_sample = latency_control_reg[SOF_LOW_LATENCY_BIT] ?
    pipe_reg[SOF_LAT_LOW-1] : pipe_reg[SOF_LAT_DEFAULT-1];

  // Toggle handshake: the held word is only replaced after the link side acked it,
  // so samples arriving faster than the link drains them are skipped, not torn
  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      ack_sync_reg <= 2'b00;
      xfer_flag_reg <= 1'b0;
      xfer_data_reg <= 14'h0000;
    end
    else
    begin
      ack_sync_reg <= {ack_sync_reg[0], flag_seen_reg};
      if (xfer_flag_reg == ack_sync_reg[1])
      begin
        xfer_data_reg <= delayed_sample;
        xfer_flag_reg <= ~xfer_flag_reg;
      end
    end
  end

  always_ff @(posedge link_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      link_rst_reg <= 2'b11;
    else
      link_rst_reg <= {link_rst_reg[0], 1'b0};
  end

  assign link_rst = link_rst_reg[1];

  always_ff @(posedge link_clk_i or posedge link_rst)
  begin
    if (link_rst)
    begin
      flag_sync_reg <= 2'b00;
      flag_seen_reg <= 1'b0;
      word_hold_reg <= 14'h0000;
      fmt_sync_reg <= 6'h00;
    end
    else
    begin
      flag_sync_reg <= {flag_sync_reg[0], xfer_flag_reg};
      fmt_sync_reg <= {fmt_sync_reg[3:0], output_rate_select_reg[SOF_RATE_MSB:SOF_RATE_LSB]};
      if (flag_sync_reg[1] != flag_seen_reg)
      begin
        word_hold_reg <= xfer_data_reg;
        flag_seen_reg <= flag_sync_reg[1];
      end
    end
  end

  assign word_bits = sof_word_bits(fmt_act_reg);
  // Both field bits may flip together, so a value is used only once two stages agree
  assign fmt_next = (fmt_sync_reg[5:4] == fmt_sync_reg[3:2]) ?
    sof_fmt_t'(fmt_sync_reg[3:2]) : fmt_act_reg;
  assign bit_cnt_next = (bit_cnt_reg == word_bits - 5'h01) ? 5'h00 : bit_cnt_reg + 5'h01;

  // One bit per link edge; the bit clock toggles every edge so data moves on both
  // of its edges, and all three lane outputs launch from the same flops
  always_ff @(posedge link_clk_i or posedge link_rst)
  begin
    if (link_rst)
    begin
      // Start at the last count so the first word after reset is a whole one
      bit_cnt_reg <= SOF_BITS_14 - 5'h01;
      fmt_act_reg <= SOF_FMT_14;
      shift_reg <= 16'h0000;
      serial_bit_clock_o <= 1'b0;
      word_frame_clock_o <= 1'b0;
    end
    else
    begin
      bit_cnt_reg <= bit_cnt_next;
      serial_bit_clock_o <= ~bit_cnt_next[0];
      word_frame_clock_o <= bit_cnt_next < {1'b0, word_bits[4:1]};
      if (bit_cnt_next == 5'h00)
      begin
        // Format changes only take effect on a word boundary
        fmt_act_reg <= fmt_next;
        shift_reg <= sof_format_word(fmt_next, word_hold_reg);
      end
      else
        shift_reg <= {shift_reg[14:0], 1'b0};
    end
  end

  assign serial_data_o = shift_reg[15];
endmodule // sof_formatter

// ### common/sof_pkg.sv
// Package: register map, field positions and link formats of the serial output formatter
package sof_pkg;
  localparam logic [7:0] SOF_ADDR_CTRL = 8'h00;
  localparam logic [7:0] SOF_ADDR_LATENCY = 8'h02;
  localparam logic [7:0] SOF_ADDR_RATE = 8'h03;
  localparam logic [7:0] SOF_ADDR_TRIM = 8'h04;
  localparam logic [15:0] SOF_REG_RESET = 16'h0000;
  localparam int SOF_SOFT_RESET_BIT = 0;
  localparam int SOF_READOUT_BIT = 1;
  localparam int SOF_LOW_LATENCY_BIT = 12;
  localparam int SOF_RATE_LSB = 13;
  localparam int SOF_RATE_MSB = 14;
  localparam int SOF_TRIM_MSB = 2;
  localparam int SOF_LAT_DEFAULT = 11;
  localparam int SOF_LAT_LOW = 8;
  localparam int SOF_SAMPLE_W = 14;
  localparam int SOF_WORD_W = 16;
  localparam int SOF_SPI_WORD = 24;
  localparam int SOF_SPI_ADDR_W = 8;
  localparam logic [4:0] SOF_BITS_12 = 5'h0c;
  localparam logic [4:0] SOF_BITS_14 = 5'h0e;
  localparam logic [4:0] SOF_BITS_16 = 5'h10;
  typedef enum logic [1:0] {
    SOF_FMT_14 = 2'b00,
    SOF_FMT_16 = 2'b01,
    SOF_FMT_RSVD = 2'b10,
    SOF_FMT_12 = 2'b11
  } sof_fmt_t;
endpackage

// ### hw/sof_spi_port.sv
// Serial register port: 24-bit address/data writes and register readout
`timescale 1ns/1ns
module sof_spi_port
  import sof_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic spi_sen_n_i,
  input wire logic spi_sclk_i,
  input wire logic spi_sdata_i,
  input wire logic readout_en_i,
  input wire logic [15:0] rd_data_i,
  output logic [7:0] rd_addr_o,
  output logic wr_strobe_o,
  output logic [7:0] wr_addr_o,
  output logic [15:0] wr_data_o,
  output logic sdout_o,
  output logic sdout_oe_o
);
  logic [1:0] sen_sync_reg;
  logic [2:0] sclk_sync_reg;
  logic [1:0] sdata_sync_reg;
  logic [4:0] bit_cnt_reg;
  logic [23:0] shift_reg;
  logic [15:0] rd_shift_reg;
  logic sclk_rise;
  logic sclk_fall;
  logic sen_active;

  // Bit 0 of each chain is only read by bit 1; edges are taken from the later stages
  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      sen_sync_reg <= 2'h3;
      sclk_sync_reg <= 3'h0;
      sdata_sync_reg <= 2'h0;
    end
    else
    begin
      sen_sync_reg <= {sen_sync_reg[0], spi_sen_n_i};
      sclk_sync_reg <= {sclk_sync_reg[1:0], spi_sclk_i};
      sdata_sync_reg <= {sdata_sync_reg[0], spi_sdata_i};
    end
  end

  assign sen_active = ~sen_sync_reg[1];
  assign sclk_rise = sclk_sync_reg[1] & ~sclk_sync_reg[2];
  assign sclk_fall = ~sclk_sync_reg[1] & sclk_sync_reg[2];
  // The last address bit is still in flight when the readout word is fetched
  assign rd_addr_o = {shift_reg[6:0], sdata_sync_reg[1]};
  assign sdout_oe_o = readout_en_i;

  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      bit_cnt_reg <= 5'h00;
      shift_reg <= 24'h000000;
      wr_strobe_o <= 1'b0;
      wr_addr_o <= 8'h00;
      wr_data_o <= 16'h0000;
    end
    else
    begin
      wr_strobe_o <= 1'b0;
      if (!sen_active)
        bit_cnt_reg <= 5'h00;
      else if (sclk_rise)
      begin
        shift_reg <= {shift_reg[22:0], sdata_sync_reg[1]};
        if (bit_cnt_reg == 5'(SOF_SPI_WORD - 1))
        begin
          // Groups of 24 repeat within one enable; a short tail is dropped
          bit_cnt_reg <= 5'h00;
          wr_strobe_o <= 1'b1;
          wr_addr_o <= shift_reg[22:15];
          wr_data_o <= {shift_reg[14:0], sdata_sync_reg[1]};
        end
        else
          bit_cnt_reg <= bit_cnt_reg + 5'h01;
      end
    end
  end

  // Readout data is launched on falling clock edges once the address is in
  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      rd_shift_reg <= 16'h0000;
      sdout_o <= 1'b0;
    end
    else if (sen_active && sclk_rise && bit_cnt_reg == 5'(SOF_SPI_ADDR_W - 1))
      rd_shift_reg <= rd_data_i;
    else if (sen_active && sclk_fall && bit_cnt_reg >= 5'(SOF_SPI_ADDR_W))
    begin
      sdout_o <= rd_shift_reg[15];
      rd_shift_reg <= {rd_shift_reg[14:0], 1'b0};
    end
  end
endmodule // sof_spi_port

// ### tb/sof_formatter_asserts.sv
// Link-side assertions for the serial output formatter
`timescale 1ns/1ns
module sof_formatter_asserts
(
  input wire logic link_clk_i,
  input wire logic sys_rst_i,
  input wire logic serial_data_o,
  input wire logic serial_bit_clock_o,
  input wire logic word_frame_clock_o
);
  logic frame_reg;
  logic [4:0] run_reg;
  logic [4:0] high_reg;
  logic [1:0] edges_reg;
  logic rise;
  logic fall;
  assign rise = word_frame_clock_o && !frame_reg;
  assign fall = !word_frame_clock_o && frame_reg;
  // Edge count hides the partial low run that follows reset
  always_ff @(posedge link_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      frame_reg <= 1'b0;
      run_reg <= 5'h00;
      high_reg <= 5'h00;
      edges_reg <= 2'h0;
    end
    else
    begin
      frame_reg <= word_frame_clock_o;
      run_reg <= (rise || fall) ? 5'h01 : run_reg + 5'h01;
      if (fall)
        high_reg <= run_reg;
      if ((rise || fall) && edges_reg != 2'h3)
        edges_reg <= edges_reg + 2'h1;
    end
  end
  default clocking cb @(posedge link_clk_i); endclocking
  default disable iff (sys_rst_i);
  bit_toggle_a: assert property (serial_bit_clock_o |=> !serial_bit_clock_o)
    else $error("bit clock stuck high");
  frame_len_a: assert property (fall && edges_reg != 2'h0 |-> run_reg inside {[5'h06:5'h08]})
    else $error("frame high length wrong");
  frame_duty_a: assert property (rise && edges_reg[1] |-> run_reg == high_reg)
    else $error("frame duty not even");
  word_start_a: assert property ($rose(word_frame_clock_o) |-> serial_bit_clock_o)
    else $error("word start off bit clock");
  frame_launch_a: assert property ($changed(word_frame_clock_o) |-> $changed(serial_bit_clock_o))
    else $error("frame edge off bit edge");
  pad_zero_a: assert property (fall && run_reg == 5'h08 |-> ##6 !serial_data_o ##1 !serial_data_o)
    else $error("pad bits not zero");
  cover property (fall && run_reg == 5'h06);
  cover property (fall && run_reg == 5'h07);
  cover property (fall && run_reg == 5'h08);
endmodule // sof_formatter_asserts

// ### tb/sof_rx_model.sv
// Capture model of the receiving logic: frames words off the serial lane
`timescale 1ns/1ns
module sof_rx_model
(
  input wire logic link_clk_i,
  input wire logic data_i,
  input wire logic frame_i,
  output logic [15:0] word_o,
  output logic [4:0] len_o,
  output int count_o
);
  logic [15:0] shift_reg = 16'h0000;
  logic [4:0] bits_reg = 5'h00;
  logic frame_reg = 1'b0;
  int count_reg = 0;
  assign count_o = count_reg;
  // A word is reported only once the next frame edge proves it complete
  always @(posedge link_clk_i)
  begin
    frame_reg <= frame_i;
    if (frame_i && !frame_reg)
    begin
      if (bits_reg != 5'h00)
      begin
        word_o <= shift_reg;
        len_o <= bits_reg;
        count_reg <= count_reg + 1;
      end
      shift_reg <= {15'h0000, data_i};
      bits_reg <= 5'h01;
    end
    else if (bits_reg != 5'h00)
    begin
      shift_reg <= {shift_reg[14:0], data_i};
      bits_reg <= bits_reg + 5'h01;
    end
  end
endmodule // sof_rx_model

// ### tb/sof_formatter_tb_top.sv
// Self-checking bench for the serial output formatter
`timescale 1ns/1ns
`define CHK(nm, e, s) begin checked++; if ((s) !== (e)) begin mismatches++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, s); end end
module sof_formatter_tb_top;
  import sof_pkg::*;
  logic clk = 1'b0;
  logic lclk = 1'b0;
  logic rst = 1'b1;
  logic [13:0] smp = 14'h0000;
  logic sen_n = 1'b1;
  logic sclk = 1'b0;
  logic sdi = 1'b0;
  logic sdout, oe, sd, bclk, word_frame_clock;
  logic [15:0] rx_word;
  logic [4:0] rx_len;
  logic [15:0] q;
  int rx_count;
  int mismatches = 0;
  int checked = 0;
  initial
    forever #2 clk = ~clk;
  initial
  begin
    #7;
    forever #40 lclk = ~lclk;
  end
  sof_formatter u_sof_formatter (.ref_clk_i(clk), .sys_rst_i(rst), .link_clk_i(lclk),
    .sample_i(smp), .spi_sen_n_i(sen_n), .spi_sclk_i(sclk), .spi_sdata_i(sdi),
    .sdout_o(sdout), .sdout_oe_o(oe), .serial_data_o(sd), .serial_bit_clock_o(bclk),
    .word_frame_clock_o(word_frame_clock));
  sof_rx_model u_sof_rx_model (.link_clk_i(lclk), .data_i(sd), .frame_i(word_frame_clock),
    .word_o(rx_word), .len_o(rx_len), .count_o(rx_count));
  task automatic report_and_stop();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Readout bits are taken in the low phase after falls 8 to 23
  task automatic spi(input logic [7:0] a, input logic [15:0] d, output logic [15:0] r);
    logic [23:0] w;
    w = {a, d};
    r = 16'h0000;
    sen_n <= 1'b0;
    repeat (6) @(posedge clk);
    for (int i = 0; i < 25; i++)
    begin
      sclk <= 1'b0;
      sdi <= (i < 24) ? w[23 - i] : 1'b0;
      repeat (6) @(posedge clk);
      if (i > 7 && i < 24)
        r = {r[14:0], sdout};
      if (i < 24)
        sclk <= 1'b1;
      repeat (6) @(posedge clk);
    end
    sen_n <= 1'b1;
    repeat (6) @(posedge clk);
  endtask
  task automatic wait_words(input int n);
    int c0;
    c0 = rx_count;
    for (int i = 0; i < 4000 && rx_count < c0 + n; i++)
      @(posedge clk);
    if (rx_count < c0 + n)
    begin
      mismatches++;
      report_and_stop();
    end
  endtask
  task automatic t_regs();
    spi(SOF_ADDR_CTRL, 16'h0002, q);
    `CHK("readout enable", 1'b1, oe)
    spi(SOF_ADDR_RATE, 16'h2000, q);
    spi(SOF_ADDR_RATE, 16'h0000, q);
    `CHK("refused write", SOF_REG_RESET, q)
    spi(SOF_ADDR_CTRL, 16'h0000, q);
    spi(SOF_ADDR_TRIM, 16'h0007, q);
    spi(8'h05, 16'hffff, q);
    spi(SOF_ADDR_CTRL, 16'h0002, q);
    spi(SOF_ADDR_TRIM, 16'h0000, q);
    `CHK("trim readback", 16'h0007, q)
    spi(SOF_ADDR_LATENCY, 16'h0000, q);
    `CHK("latency reset", SOF_REG_RESET, q)
    spi(SOF_ADDR_CTRL, 16'h0000, q);
    `CHK("readout off", 1'b0, oe)
    $display("register test done");
  endtask
  task automatic t_fmt(input logic [15:0] rate, input logic [15:0] trim, input logic [4:0] n,
    input logic [13:0] s);
    logic [15:0] e;
    e = (n == 5'h0c) ? {4'h0, s[13:2]} : (n == 5'h10) ? {s, 2'b00} : {2'b00, s};
    spi(SOF_ADDR_RATE, rate, q);
    spi(SOF_ADDR_TRIM, trim, q);
    smp <= s;
    wait_words(4);
    `CHK("word length", n, rx_len)
    `CHK("word", e, rx_word)
    $display("format %0d bits done", n);
  endtask
  initial
  begin
    repeat (4) @(posedge clk);
    repeat (3) @(posedge lclk);
    @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    t_regs();
    t_fmt(16'h6000, 16'h0002, 5'h0c, 14'h2d5b);
    spi(SOF_ADDR_LATENCY, 16'h1000, q);
    t_fmt(16'h2000, 16'h0000, 5'h10, 14'h1a67);
    t_fmt(16'h0000, 16'h0000, 5'h0e, 14'h3c39);
    report_and_stop();
  end
endmodule // sof_formatter_tb_top
bind sof_formatter sof_formatter_asserts u_sof_formatter_asserts (.link_clk_i(link_clk_i),
  .sys_rst_i(sys_rst_i), .serial_data_o(serial_data_o),
  .serial_bit_clock_o(serial_bit_clock_o), .word_frame_clock_o(word_frame_clock_o));
